// [rxds_cfg.svh]
// Purpose: constants for the receive deserializer block
// Assumes: AHB-Lite word registers, byte address = register index * 4
// Notes:   definitions only
`ifndef RXDS_CFG_SVH
`define RXDS_CFG_SVH

// Register indices (byte address is index * 4)
`define RXDS_IDX_CTRL       6'h06
`define RXDS_IDX_INTEN      6'h07
`define RXDS_IDX_STAT       6'h08
`define RXDS_IDX_DATA_A     6'h09
`define RXDS_IDX_DATA_B     6'h0B

// Reset values
`define RXDS_CTRL_RST       4'h3
`define RXDS_INTEN_RST      8'h00

// Control register fields
`define RXDS_CTRL_BYTE_BIT  3
`define RXDS_CTRL_LEN_MSB   2

// Per-channel nibble layout of enable and status registers
`define RXDS_CH_BITS        4
`define RXDS_F_FULL         0
`define RXDS_F_EOF          1
`define RXDS_F_FLOW         2
`define RXDS_F_TOP          3

// Bit count at which a byte is complete
`define RXDS_LAST_BIT       3'h7

`endif

// [rxds_pkg.sv]
// Purpose: shared types of the receive deserializer block
// Assumes: nothing beyond the config header
// Notes:   constants live in rxds_cfg.svh
package rxds_pkg;

	// Receiver assembly state
	typedef enum logic [0:0]
	{
		rxds_ch_idle = 1'b0,
		rxds_ch_asm  = 1'b1
	} rxds_ch_state_t;

	// Bus slave phase
	typedef enum logic [0:0]
	{
		rxds_bus_addr = 1'b0,
		rxds_bus_data = 1'b1
	} rxds_bus_state_t;

	typedef logic [7:0] rxds_byte_t;

endpackage : rxds_pkg

// [rxds_chan_if.sv]
// Purpose: signals between the register side and one channel receiver
// Assumes: single clock domain
// Notes:   ctl is the register side, chan is the receiver
`timescale 1ns/100ps
interface rxds_chan_if;
	logic               bit_tick;
	logic               bit_valid;
	logic               bit_data;
	logic               byte_mode;
	logic [2:0]         eof_len;
	logic               hold_read;
	rxds_pkg::rxds_byte_t hold_data;
	logic               hold_full;
	logic               hold_all_valid;
	logic               full_evt;
	logic               ovf_evt;
	logic               eof_evt;
	logic               ser_bit;
	logic               ser_val;

	modport ctl
	(
		output bit_tick, bit_valid, bit_data, byte_mode, eof_len, hold_read,
		input  hold_data, hold_full, hold_all_valid, full_evt, ovf_evt,
		input  eof_evt, ser_bit, ser_val
	);

	modport chan
	(
		input  bit_tick, bit_valid, bit_data, byte_mode, eof_len, hold_read,
		output hold_data, hold_full, hold_all_valid, full_evt, ovf_evt,
		output eof_evt, ser_bit, ser_val
	);
endinterface : rxds_chan_if

// [rxds_chan.sv]
// Purpose: one channel receiver, byte assembly, frame end, holding register
// Assumes: bit_tick marks one bit time; bit_valid marks a correlation
// Notes:   events are one-cycle pulses registered here
`timescale 1ns/100ps
`include "rxds_cfg.svh"
module rxds_chan
(
	// Clock and reset
	input wire logic  mclk,
	input wire logic  nrst,
	input wire logic  ce,
	// Register side
	rxds_chan_if.chan cif
);

	rxds_pkg::rxds_ch_state_t state_ff;
	rxds_pkg::rxds_byte_t     shift_ff;
	logic [2:0]               cnt_ff;
	logic [3:0]               gap_ff;
	logic [3:0]               nxt_gap;
	logic                     got_bit;
	logic                     byte_done;
	logic                     eof_hit;
	logic                     load;
	rxds_pkg::rxds_byte_t     load_data;

	////////////////////////////////////////////////////////////////////////
	// Bit-time decode
	assign got_bit   = cif.bit_tick & cif.bit_valid;
	assign nxt_gap   = gap_ff + 4'h1;
	// Gap counting only starts once a valid bit was seen
	assign eof_hit   = cif.bit_tick & ~cif.bit_valid
		& (state_ff == rxds_pkg::rxds_ch_asm)
		& (nxt_gap > {1'b0, cif.eof_len});
	assign byte_done = got_bit & (cnt_ff == `RXDS_LAST_BIT)
		& cif.byte_mode;
	// Partial byte moves on frame end only if bits are pending
	assign load      = byte_done
		| (eof_hit & (cnt_ff != 3'h0) & cif.byte_mode);
	assign load_data = byte_done ? {shift_ff[6:0], cif.bit_data} : shift_ff;

	////////////////////////////////////////////////////////////////////////
	// Assembly and gap counter
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= rxds_pkg::rxds_ch_idle;
			shift_ff <= 8'h00;
			cnt_ff   <= 3'h0;
			gap_ff   <= 4'h0;
		end
		else if (ce)
		begin
			if (got_bit)
			begin
				// Empty the shifter after a whole byte, so a later
				// partial byte carries no stale upper bits
				if (byte_done)
					shift_ff <= 8'h00;
				else
					shift_ff <= {shift_ff[6:0], cif.bit_data};
				cnt_ff   <= cnt_ff + 3'h1;   // Wraps after a full byte
				gap_ff   <= 4'h0;
				state_ff <= rxds_pkg::rxds_ch_asm;
			end
			else if (eof_hit)
			begin
				state_ff <= rxds_pkg::rxds_ch_idle;
				shift_ff <= 8'h00;
				cnt_ff   <= 3'h0;
				gap_ff   <= 4'h0;
			end
			else if (cif.bit_tick && state_ff == rxds_pkg::rxds_ch_asm)
				gap_ff <= nxt_gap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Holding register; a load in the read cycle keeps it full
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cif.hold_data      <= 8'h00;
			cif.hold_full      <= 1'b0;
			cif.hold_all_valid <= 1'b0;
		end
		else if (ce)
		begin
			if (load)
			begin
				cif.hold_data      <= load_data;
				cif.hold_full      <= 1'b1;
				cif.hold_all_valid <= byte_done;
			end
			else if (cif.hold_read)
				cif.hold_full <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event pulses and bit-serial mirror
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cif.full_evt <= 1'b0;
			cif.ovf_evt  <= 1'b0;
			cif.eof_evt  <= 1'b0;
			cif.ser_bit  <= 1'b0;
			cif.ser_val  <= 1'b0;
		end
		else if (ce)
		begin
			cif.full_evt <= load;
			// Unread byte overwritten counts as overflow
			cif.ovf_evt  <= load & cif.hold_full & ~cif.hold_read;
			cif.eof_evt  <= eof_hit;
			if (got_bit)
				cif.ser_bit <= cif.bit_data;
			cif.ser_val  <= got_bit & ~cif.byte_mode;
		end
	end

endmodule : rxds_chan

// [rxds_top.sv]
// Purpose: receive deserializer registers, two channels, interrupt request
// Assumes: AHB-Lite single word transfers, one slave on the bus
// Notes:   every transfer takes one wait state; response always OKAY
//
// Operation
// - Control bit 3 picks byte transfers (1) or raw bit-serial transfers (0).
// - In byte mode the host reads payload one byte per access, whole or partial.
// - Control bits 2:0 hold the frame-end gap length in bit times.
// - Gap bit times are counted only after a valid bit arrived.
// - Frame end moves the partial byte to the holding register.
// - Gap length zero ends the frame at the first invalid bit.
// - Enable bit 7 gates the channel B underflow interrupt.
// - Reading empty channel B data register flags underflow.
// - Enable bit 6 gates the channel B overflow interrupt.
// - Loading channel B holding register before it was read flags overflow.
// - Enable bit 5 gates the channel B frame-end interrupt.
// - Frame end needs one bit, then invalid bits beyond the gap length.
// - Reading the status register clears pending frame-end requests.
// - Enable bit 4 gates the channel B full interrupt.
// - Full rises on every transfer into the holding register.
// - Enable bits 3:0 do the same for channel A.
`timescale 1ns/100ps
`include "rxds_cfg.svh"
module rxds_top
(
	// Clock, reset, clock enable
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Correlator receivers, bit 0 channel A, bit 1 channel B
	input  wire logic [1:0]  rx_bit_tick,
	input  wire logic [1:0]  rx_bit_valid,
	input  wire logic [1:0]  rx_bit_data,
	// Bit-serial pins toward the host
	output logic             serial_data_pin,
	output logic             serial_data_valid_pin,
	// Interrupt request, active high
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// Address test used by the read mux and by the access side effects
	function automatic logic at_reg(input logic [5:0] idx,
	                                input logic [5:0] want);
		at_reg = (idx == want);
	endfunction : at_reg

	rxds_pkg::rxds_bus_state_t bus_ff;
	logic [5:0]                idx_ff;
	logic                      wr_ff;
	logic [3:0]                ctrl_ff;
	logic [7:0]                inten_ff;
	logic [1:0]                unf_ff;
	logic [1:0]                ovf_ff;
	logic [1:0]                eof_ff;
	logic [1:0]                full_w;
	logic [1:0]                ovf_evt_w;
	logic [1:0]                eof_evt_w;
	logic [1:0]                ser_bit_w;
	logic [1:0]                ser_val_w;
	logic [1:0]                rd_data_w;
	logic [7:0]                pend_w;
	logic [7:0]                stat_w;
	rxds_pkg::rxds_byte_t      hold_w [2];
	logic                      take;
	logic                      in_data;
	logic                      rd_stat;
	logic                      wr_go;
	logic [7:0]                rd_mux;

	////////////////////////////////////////////////////////////////////////
	// Bus decode; hsize is always a word here, so it is not checked
	assign take    = hsel & htrans[1] & hready
		& (bus_ff == rxds_pkg::rxds_bus_addr);
	assign in_data = (bus_ff == rxds_pkg::rxds_bus_data) & ce;
	assign wr_go   = in_data & wr_ff;
	assign rd_stat = in_data & ~wr_ff & at_reg(idx_ff, `RXDS_IDX_STAT);
	assign rd_data_w[0] = in_data & ~wr_ff
		& at_reg(idx_ff, `RXDS_IDX_DATA_A);
	assign rd_data_w[1] = in_data & ~wr_ff
		& at_reg(idx_ff, `RXDS_IDX_DATA_B);

	////////////////////////////////////////////////////////////////////////
	// Channel receivers and their pending flags
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			rxds_chan_if cif ();

			assign cif.bit_tick   = rx_bit_tick[ch];
			assign cif.bit_valid  = rx_bit_valid[ch];
			assign cif.bit_data   = rx_bit_data[ch];
			assign cif.byte_mode  = ctrl_ff[`RXDS_CTRL_BYTE_BIT];
			assign cif.eof_len    = ctrl_ff[`RXDS_CTRL_LEN_MSB:0];
			assign cif.hold_read  = rd_data_w[ch];
			assign full_w[ch]     = cif.hold_full;
			assign ovf_evt_w[ch]  = cif.ovf_evt;
			assign eof_evt_w[ch]  = cif.eof_evt;
			assign ser_bit_w[ch]  = cif.ser_bit;
			assign ser_val_w[ch]  = cif.ser_val;
			assign hold_w[ch]     = cif.hold_data;

			// Pending nibble: underflow, overflow, frame end, full
			assign pend_w[ch*4 +: 4] = {unf_ff[ch], ovf_ff[ch],
				eof_ff[ch], full_w[ch]};
			assign stat_w[ch*4 +: 4] = {cif.hold_all_valid,
				unf_ff[ch] | ovf_ff[ch], eof_ff[ch], full_w[ch]};

			rxds_chan u_chan
			(
				.mclk (mclk),
				.nrst (nrst),
				.ce   (ce),
				.cif  (cif.chan)
			);

			// Sticky flags; a new event beats the status-read clear
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
				begin
					unf_ff[ch] <= 1'b0;
					ovf_ff[ch] <= 1'b0;
					eof_ff[ch] <= 1'b0;
				end
				else if (ce)
				begin
					if (rd_data_w[ch] && !full_w[ch])
						unf_ff[ch] <= 1'b1;
					else if (rd_stat)
						unf_ff[ch] <= 1'b0;
					if (ovf_evt_w[ch])
						ovf_ff[ch] <= 1'b1;
					else if (rd_stat)
						ovf_ff[ch] <= 1'b0;
					if (eof_evt_w[ch])
						eof_ff[ch] <= 1'b1;
					else if (rd_stat)
						eof_ff[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero, upper bits always zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (at_reg(idx_ff, `RXDS_IDX_CTRL))
			rd_mux = {4'h0, ctrl_ff};
		else if (at_reg(idx_ff, `RXDS_IDX_INTEN))
			rd_mux = inten_ff;
		else if (at_reg(idx_ff, `RXDS_IDX_STAT))
			rd_mux = stat_w;
		else if (at_reg(idx_ff, `RXDS_IDX_DATA_A))
			rd_mux = hold_w[0];
		else if (at_reg(idx_ff, `RXDS_IDX_DATA_B))
			rd_mux = hold_w[1];
	end

	////////////////////////////////////////////////////////////////////////
	// Bus phase tracking; one wait state lets read data come from a flop
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			bus_ff    <= rxds_pkg::rxds_bus_addr;
			idx_ff    <= 6'h00;
			wr_ff     <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end
		else if (ce)
		begin
			hresp <= 1'b0;   // Every access answers OKAY
			case (bus_ff)
				rxds_pkg::rxds_bus_addr:
				begin
					if (take)
					begin
						idx_ff    <= haddr[7:2];
						wr_ff     <= hwrite;
						hreadyout <= 1'b0;
						bus_ff    <= rxds_pkg::rxds_bus_data;
					end
				end
				rxds_pkg::rxds_bus_data:
				begin
					if (!wr_ff)
						hrdata <= {24'h00_0000, rd_mux};
					hreadyout <= 1'b1;
					bus_ff    <= rxds_pkg::rxds_bus_addr;
				end
				default:
				begin
					hreadyout <= 1'b1;
					bus_ff    <= rxds_pkg::rxds_bus_addr;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Writable registers; the reserved control bits are not stored
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_ff  <= `RXDS_CTRL_RST;
			inten_ff <= `RXDS_INTEN_RST;
		end
		else if (ce && wr_go)
		begin
			if (at_reg(idx_ff, `RXDS_IDX_CTRL))
				ctrl_ff <= hwdata[3:0];
			if (at_reg(idx_ff, `RXDS_IDX_INTEN))
				inten_ff <= hwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt and bit-serial outputs, channel A drives the serial pins
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq                   <= 1'b0;
			serial_data_pin       <= 1'b0;
			serial_data_valid_pin <= 1'b0;
		end
		else if (ce)
		begin
			irq                   <= |(pend_w & inten_ff);
			serial_data_pin       <= ser_bit_w[0];
			serial_data_valid_pin <= ser_val_w[0];
		end
	end

endmodule : rxds_top

// [rxds_top_sva.sv]
// Purpose: port checker for the receive deserializer top
// Assumes: one slave, hready tied to hreadyout
// Notes:   shadows lag the design by one edge
`timescale 1ns/100ps
`include "rxds_cfg.svh"
module rxds_top_sva
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        ce,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Receivers and pins
	input wire logic [1:0]  rx_bit_tick,
	input wire logic [1:0]  rx_bit_valid,
	input wire logic [1:0]  rx_bit_data,
	input wire logic        serial_data_pin,
	input wire logic        serial_data_valid_pin,
	input wire logic        irq
);
	logic       take;
	logic       done;
	logic       ph_ff;
	logic [6:0] cmd_ff;
	logic [7:0] inten_ff;
	logic       byte_ff;

	// Accepted transfer and finished data phase
	assign take = hsel && htrans[1] && hready && hreadyout && ce;
	assign done = ph_ff && hreadyout && ce;

	// Data phase tracking; back to back keeps it set
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ph_ff <= 1'b0;
		else if (take || done)
			ph_ff <= take;
	end

	// Direction and index of the pending transfer
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cmd_ff <= 7'h00;
		else if (take)
			cmd_ff <= {hwrite, haddr[7:2]};
	end

	// Enable shadow
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			inten_ff <= `RXDS_INTEN_RST;
		else if (done && cmd_ff == {1'b1, `RXDS_IDX_INTEN})
			inten_ff <= hwdata[7:0];
	end

	// Byte mode shadow
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			byte_ff <= 1'b0;
		else if (done && cmd_ff == {1'b1, `RXDS_IDX_CTRL})
			byte_ff <= hwdata[3];
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////
	hready_wait_a:
	assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("bus wait state not exactly one");
	hresp_okay_a:
	assert property (hresp == 1'b0)
		else $error("bus response not okay");
	rd_upper_a:
	assert property (done && !cmd_ff[6] |-> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	ctrl_read_a:
	assert property (done && cmd_ff == {1'b0, `RXDS_IDX_CTRL}
		|-> hrdata[7:3] == {4'h0, byte_ff})
		else $error("control readback wrong");
	irq_quiet_a:
	assert property ((inten_ff == 8'h00) [*3] |-> !irq)
		else $error("irq with all enables off");
	irq_cause_a:
	assert property ($rose(irq) |-> inten_ff != 8'h00)
		else $error("irq rose with no enable");
	ser_mode_a:
	assert property (byte_ff && $past(byte_ff) |-> !serial_data_valid_pin)
		else $error("serial pulse in byte mode");
	// Pins sit two flops behind the correlator tick
	ser_valid_a:
	assert property (serial_data_valid_pin
		|-> $past(rx_bit_tick[0] && rx_bit_valid[0], 2))
		else $error("serial pulse without valid bit");
	ser_data_a:
	assert property (serial_data_valid_pin
		|-> serial_data_pin == $past(rx_bit_data[0], 2))
		else $error("serial data pin wrong");

	// Main scenarios reached
	cover property (take && hwrite);
	cover property ($rose(irq));
	cover property (serial_data_valid_pin);
endmodule : rxds_top_sva

bind rxds_top rxds_top_sva chk_u
(
	.mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.rx_bit_tick(rx_bit_tick), .rx_bit_valid(rx_bit_valid),
	.rx_bit_data(rx_bit_data), .serial_data_pin(serial_data_pin),
	.serial_data_valid_pin(serial_data_valid_pin), .irq(irq)
);

// [rxds_corr_model.sv]
// Purpose: behavioural correlator pair feeding the receivers
// Assumes: one bit time is two clocks
// Notes:   data line never rests on the last bit between ticks
`timescale 1ns/100ps
module rxds_corr_model
(
	// Clock
	input wire logic   mclk,
	// Correlator outputs, bit 0 channel A, bit 1 channel B
	output logic [1:0] rx_bit_tick,
	output logic [1:0] rx_bit_valid,
	output logic [1:0] rx_bit_data
);
	// Quiet at time zero
	initial
	begin
		rx_bit_tick  = 2'h0;
		rx_bit_valid = 2'h0;
		rx_bit_data  = 2'h0;
	end

	// n valid bits, MSB first, then gap invalid ticks
	task automatic send(input int ch, input logic [7:0] bits,
		input int n, input int gap);
		for (int i = 0; i < n + gap; i++)
		begin
			@(posedge mclk);
			rx_bit_tick[ch]  <= 1'b1;
			rx_bit_valid[ch] <= (i < n);
			rx_bit_data[ch]  <= (i < n) ? bits[n - 1 - i] : ~rx_bit_data[ch];
			@(posedge mclk);
			rx_bit_tick[ch]  <= 1'b0;
			rx_bit_valid[ch] <= 1'b0;
			rx_bit_data[ch]  <= ~rx_bit_data[ch];
		end
	endtask : send
endmodule : rxds_corr_model

// [rx_byte_deserializer_irq_enable_tb.sv]
// Purpose: self-checking bench for the receive deserializer
// Assumes: ce high except in the freeze test, word transfers only
// Notes:   byte addresses are register index times four
`timescale 1ns/100ps
module rx_byte_deserializer_irq_enable_tb;
	logic        mclk;
	logic        nrst;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  rx_bit_tick;
	logic [1:0]  rx_bit_valid;
	logic [1:0]  rx_bit_data;
	logic        serial_data_pin;
	logic        serial_data_valid_pin;
	logic        irq;
	logic [7:0]  rdv;
	int          num_errors;
	int          comparisons;
	int          cyc;
	int          pulses;

	rxds_top dut_u
	(
		.mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .rx_bit_tick(rx_bit_tick),
		.rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data),
		.serial_data_pin(serial_data_pin),
		.serial_data_valid_pin(serial_data_valid_pin), .irq(irq)
	);
	rxds_corr_model corr_u
	(
		.mclk(mclk), .rx_bit_tick(rx_bit_tick),
		.rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data)
	);

	// Clock, pulse count and hang guard
	always #10 mclk = ~mclk;
	always @(posedge mclk)
	begin
		pulses <= pulses + (serial_data_valid_pin === 1'b1);
		cyc    <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One single transfer; waits are bounded by the hang guard only
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge mclk);
		while (hreadyout !== 1'b1)
			@(posedge mclk);
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		@(posedge mclk);
		while (hreadyout !== 1'b1)
			@(posedge mclk);
		rdv = hrdata[7:0];
	endtask : bus

	task automatic irq_is(input logic lvl);
		repeat (4) @(posedge mclk);
		chk({7'h00, irq}, {7'h00, lvl}, "irq level");
	endtask : irq_is

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		bus(1'b0, 8'h18, 8'h00);
		chk(rdv, 8'h03, "ctrl reset");
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv, 8'h00, "status reset");
		bus(1'b1, 8'h3C, 8'hFF);
		bus(1'b0, 8'h3C, 8'h00);
		chk(rdv, 8'h00, "unmapped");
		bus(1'b1, 8'h1C, 8'hA5);
		bus(1'b0, 8'h1C, 8'h00);
		chk(rdv, 8'hA5, "enable readback");
		bus(1'b1, 8'h1C, 8'h00);
		bus(1'b1, 8'h18, 8'h08);
		bus(1'b0, 8'h18, 8'h00);
		chk(rdv, 8'h08, "byte mode on");
		$display("register test done");
	endtask : t_regs

	// Full byte, then underflow masked and unmasked
	task automatic t_full_under;
		bus(1'b1, 8'h1C, 8'h10);
		corr_u.send(1, 8'hA7, 8, 0);
		irq_is(1'b1);
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv, 8'h90, "status full b");
		bus(1'b0, 8'h2C, 8'h00);
		chk(rdv, 8'hA7, "data b");
		irq_is(1'b0);
		bus(1'b1, 8'h1C, 8'h00);
		bus(1'b0, 8'h2C, 8'h00);
		irq_is(1'b0);
		bus(1'b1, 8'h1C, 8'h80);
		irq_is(1'b1);
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv & 8'h40, 8'h40, "underflow flag");
		irq_is(1'b0);
		$display("full and underflow test done");
	endtask : t_full_under

	task automatic t_over;
		bus(1'b1, 8'h1C, 8'h40);
		corr_u.send(1, 8'h11, 8, 0);
		corr_u.send(1, 8'h22, 8, 0);
		irq_is(1'b1);
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv & 8'h50, 8'h50, "overflow flag");
		irq_is(1'b0);
		bus(1'b0, 8'h2C, 8'h00);
		chk(rdv, 8'h22, "newest byte kept");
		$display("overflow test done");
	endtask : t_over

	// Gap of exactly len keeps the frame open; one more ends it
	task automatic t_eof;
		for (int len = 0; len < 8; len += 7)
		begin
			bus(1'b1, 8'h18, 8'h08 | 8'(len));
			bus(1'b1, 8'h1C, 8'h20);
			corr_u.send(1, 8'h05, 3, len);
			bus(1'b0, 8'h20, 8'h00);
			chk(rdv & 8'h30, 8'h00, "early frame end");
			corr_u.send(1, 8'h00, 0, 1);
			irq_is(1'b1);
			bus(1'b0, 8'h20, 8'h00);
			chk(rdv & 8'h30, 8'h30, "frame end flags");
			irq_is(1'b0);
			bus(1'b0, 8'h2C, 8'h00);
			chk(rdv, 8'h05, "partial byte");
			corr_u.send(1, 8'h00, 0, 9);
			bus(1'b0, 8'h20, 8'h00);
			chk(rdv & 8'h30, 8'h00, "idle gap");
		end
		$display("frame end test done");
	endtask : t_eof

	// Channel A in byte mode, then bit-serial pins
	task automatic t_chan_a;
		int p0;
		bus(1'b1, 8'h18, 8'h08);
		bus(1'b1, 8'h1C, 8'h01);
		p0 = pulses;
		corr_u.send(0, 8'h3C, 8, 0);
		irq_is(1'b1);
		chk(8'(pulses - p0), 8'h00, "pulses in byte mode");
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv & 8'h0F, 8'h09, "status a");
		bus(1'b0, 8'h24, 8'h00);
		chk(rdv, 8'h3C, "data a");
		bus(1'b1, 8'h18, 8'h03);
		p0 = pulses;
		corr_u.send(0, 8'hC5, 8, 0);
		repeat (4) @(posedge mclk);
		chk(8'(pulses - p0), 8'h08, "serial pulses");
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv & 8'h01, 8'h00, "no full in bit mode");
		$display("channel a test done");
	endtask : t_chan_a

	// Clock enable low freezes the receivers; the whole byte is lost
	task automatic t_freeze;
		bus(1'b1, 8'h18, 8'h08);
		@(posedge mclk);
		ce <= 1'b0;
		corr_u.send(1, 8'h5A, 8, 0);
		@(posedge mclk);
		ce <= 1'b1;
		bus(1'b0, 8'h20, 8'h00);
		chk(rdv & 8'h10, 8'h00, "full while frozen");
		$display("clock enable test done");
	endtask : t_freeze

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// Reset for 16 clocks, then the scenarios
	initial
	begin
		mclk        = 1'b0;
		nrst        = 1'b0;
		ce          = 1'b1;
		hsel        = 1'b1;
		haddr       = 32'h00000000;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hwdata      = 32'h00000000;
		num_errors  = 0;
		comparisons = 0;
		cyc         = 0;
		pulses      = 0;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		t_regs();
		t_full_under();
		t_over();
		t_eof();
		t_chan_a();
		t_freeze();
		end_of_test();
	end
endmodule : rx_byte_deserializer_irq_enable_tb
